// >>> core/coproc_regs_pkg.sv
`default_nettype none
package coproc_regs_pkg;

    // byte offsets of the register set
    localparam logic [7:0] off_status = 8'h10;
    localparam logic [7:0] off_control = 8'h11;
    localparam logic [7:0] off_select = 8'h12;
    localparam logic [7:0] off_queue = 8'h13;
    localparam logic [7:0] off_base = 8'h14;
    localparam logic [7:0] off_width = 8'h18;
    localparam logic [7:0] off_height = 8'h1a;
    localparam logic [7:0] off_format = 8'h1c;

    // descriptor storage shape
    localparam int desc_bytes = 9;
    localparam int desc_bits = 72;
    localparam int desc_banks = 4;
    localparam logic [3:0] lane_width_hi = 4'h5;
    localparam logic [3:0] lane_height_hi = 4'h7;
    localparam logic [3:0] lane_format = 4'h8;

    // status field positions
    localparam int st_map_lsb = 0;
    localparam int st_dir_bit = 2;
    localparam int st_valid_bit = 3;
    localparam int st_restart_bit = 4;
    localparam int st_line_bit = 5;
    localparam int st_busy_bit = 7;

    // control field positions
    localparam int ctl_irq_en_bit = 0;
    localparam int ctl_master_bit = 1;
    localparam int ctl_pend_bit = 4;
    localparam int ctl_abort_bit = 5;
    localparam int ctl_turbo_bit = 6;

    // queue status and format field positions
    localparam int q_ovf_bit = 7;
    localparam int fmt_endian_bit = 3;
    localparam int fmt_sysmem_bit = 7;

    // writable bits of partly reserved bytes
    localparam logic [7:0] dim_hi_mask = 8'h0f;
    localparam logic [7:0] fmt_mask = 8'h8f;
    localparam logic [7:0] full_mask = 8'hff;

    // reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] queue_reset = 8'h00;
    localparam logic [1:0] select_reset = 2'h0;
    localparam logic [desc_bits-1:0] desc_reset = 72'h0;

    typedef enum logic [1:0] {
        map_pattern = 2'b00,
        map_mask = 2'b01,
        map_source = 2'b10,
        map_dest = 2'b11
    } map_kind_e;

    typedef enum logic [1:0] {
        desc_mask_map = 2'b00,
        desc_map_a = 2'b01,
        desc_map_b = 2'b10,
        desc_map_c = 2'b11
    } desc_sel_e;

    typedef enum logic [2:0] {
        depth_1 = 3'b000,
        depth_8 = 3'b011,
        depth_16 = 3'b100,
        depth_32 = 3'b101
    } depth_e;

endpackage : coproc_regs_pkg
`default_nettype wire

// >>> core/map_desc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module map_desc_mem (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // byte write into one bank
    input wire logic wr_en,
    input wire logic [1:0] wr_bank,
    input wire logic [3:0] wr_lane,
    input wire logic [7:0] wr_data,
    // registered read of one bank
    input wire logic [1:0] rd_bank,
    output logic [coproc_regs_pkg::desc_bits-1:0] rd_data
);
    import coproc_regs_pkg::*;

    logic [desc_bits-1:0] bank_r [desc_banks];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < desc_banks; i++)
            begin
                bank_r[i] <= desc_reset;
            end
        end
        else if (wr_en)
        begin
            bank_r[wr_bank][wr_lane*8 +: 8] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data <= desc_reset;
        end
        else
        begin
            rd_data <= bank_r[rd_bank];
        end
    end

endmodule : map_desc_mem
`default_nettype wire

// >>> core/drawing_coproc_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) status bits 1-0 name the map needing host data next
// (R2) status bit 2: 1 write to screen, 0 read back to system
// (R3) status bit 3 marks bits 1-0 valid; software rereads until set
// (R4) status bit 4: 1 restart at map start, 0 increment address
// (R5) status bit 5: 1 advance to next line, 0 stay on line
// (R6) status bit 7 shows busy; reading it never disturbs the engine
// (R7) completion irq always raised; reaches pin only when control bit 0 set
// (R8) control bit 1 picks bus-master (1) or cpu-assisted (0) transfers
// (R9) control bit 4 shows pending irq; writing 0 clears, 1 no effect
// (R10) control bit 5 write 1 aborts; self-clears once engine stopped
// (R11) control bit 6 removes one datapath clock; only for slow clocks
// (R12) two-bit select picks mask map, map a, map b or map c
// (R13) four-bit free queue entry count in words, read only
// (R14) writes beyond free entries are dropped and set overflow bit 7
// (R15) reading queue status clears the overflow flag
// (R16) each descriptor holds a 32-bit byte base pointer
// (R17) width and height are 12-bit minus-one counts; top bits reserved
// (R18) format bits 2-0 code depth: 1, 8, 16 or 32 bits
// (R19) format bit 3 picks little (0) or big (1) endian order
// (R20) registers memory mapped only, mostly readable for save/restore
// (R21) format bit 7 marks a map held in system memory
// (R22) descriptor registers banked; access reaches only the selected bank
module drawing_coproc_control_regs (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // memory-mapped register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // drawing engine state
    input wire coproc_regs_pkg::map_kind_e eng_map_need,
    input wire logic eng_write_dir,
    input wire logic eng_map_valid,
    input wire logic eng_restart,
    input wire logic eng_next_line,
    input wire logic eng_busy,
    input wire logic eng_done,
    input wire logic eng_stopped,
    // command queue
    input wire logic [3:0] queue_free,
    input wire logic cmd_wr,
    output logic cmd_push,
    // engine controls
    output logic master_mode,
    output logic abort_req,
    output logic turbo_path,
    // selected descriptor
    output coproc_regs_pkg::desc_sel_e map_select,
    output logic sel_sysmem,
    output logic sel_big_endian,
    output logic [5:0] sel_bpp,
    // interrupt pin
    input wire logic legacy_irq_n,
    output logic irq_out_pin_n
);
    import coproc_regs_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // writable bits of each descriptor byte; reserved bits stay zero
    function automatic logic [7:0] lane_mask(input logic [3:0] lane);
        logic [7:0] m;
        m = full_mask;
        if (lane == lane_width_hi || lane == lane_height_hi)
        begin
            m = dim_hi_mask;
        end
        else if (lane == lane_format)
        begin
            m = fmt_mask;
        end
        return m;
    endfunction : lane_mask

    // pixel depth in bits, zero for reserved codes
    function automatic logic [5:0] depth_bits(input logic [2:0] code);
        logic [5:0] b;
        b = 6'h00;
        case (code)
            depth_1: b = 6'h01;
            depth_8: b = 6'h08;
            depth_16: b = 6'h10;
            depth_32: b = 6'h20;
            default: b = 6'h00;
        endcase
        return b;
    endfunction : depth_bits

    logic [7:0] status_r;
    logic irq_en_r;
    logic pend_r;
    logic ovf_r;
    logic ctl_wr;
    logic queue_rd;
    logic is_desc;
    logic [3:0] lane;
    logic [desc_bits-1:0] desc_rd;
    logic rd_p1_r;
    logic desc_p1_r;
    logic [3:0] lane_p1_r;
    logic [7:0] local_p1_r;
    logic [7:0] local_val;

    assign ctl_wr = reg_wr && reg_addr == off_control;
    assign queue_rd = reg_rd && reg_addr == off_queue;
    assign is_desc = reg_addr >= off_base && reg_addr <= off_format;
    assign lane = 4'(reg_addr - off_base);

    // engine state sampled every cycle; reads only look at the copy
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_r <= 8'h00;
        end
        else
        begin
            status_r[st_map_lsb +: 2] <= eng_map_need; // R1
            status_r[st_dir_bit] <= eng_write_dir; // R2
            status_r[st_valid_bit] <= eng_map_valid; // R3
            status_r[st_restart_bit] <= eng_restart; // R4
            status_r[st_line_bit] <= eng_next_line; // R5
            status_r[st_busy_bit] <= eng_busy; // R6
        end
    end

    map_status_a: assert property (
        status_r[st_map_lsb +: 2] == $past(eng_map_need)) // R1
        else $error("map indication does not follow engine");
    dir_status_a: assert property (
        $rose(eng_write_dir) |=> status_r[st_dir_bit]) // R2
        else $error("direction bit missed engine change");
    valid_status_a: assert property (
        !eng_map_valid |=> !status_r[st_valid_bit]) // R3
        else $error("map valid shown while engine says invalid");
    restart_line_a: assert property (
        status_r[st_restart_bit] == $past(eng_restart)
        && status_r[st_line_bit] == $past(eng_next_line)) // R4
        else $error("restart or next line bit wrong");

    // control register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_en_r <= control_reset[ctl_irq_en_bit];
            master_mode <= control_reset[ctl_master_bit];
            turbo_path <= control_reset[ctl_turbo_bit];
        end
        else if (ctl_wr)
        begin
            irq_en_r <= reg_wdata[ctl_irq_en_bit]; // R7
            master_mode <= reg_wdata[ctl_master_bit]; // R8
            turbo_path <= reg_wdata[ctl_turbo_bit]; // R11
        end
    end

    // completion always latched; set wins over a clearing write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_r <= control_reset[ctl_pend_bit];
        end
        else if (eng_done)
        begin
            pend_r <= 1'b1; // R7
        end
        else if (ctl_wr && !reg_wdata[ctl_pend_bit])
        begin
            pend_r <= 1'b0; // R9
        end
    end

    // abort held until the engine reports it has really stopped
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            abort_req <= control_reset[ctl_abort_bit];
        end
        else if (ctl_wr && reg_wdata[ctl_abort_bit])
        begin
            abort_req <= 1'b1; // R10
        end
        else if (eng_stopped)
        begin
            abort_req <= 1'b0; // R10
        end
    end

    sequence abort_write_s;
        ctl_wr && reg_wdata[ctl_abort_bit];
    endsequence
    sequence engine_halt_s;
        abort_req && eng_stopped && !(ctl_wr && reg_wdata[ctl_abort_bit]);
    endsequence
    abort_set_a: assert property (abort_write_s |=> abort_req) // R10
        else $error("abort write not taken");
    abort_clear_a: assert property (engine_halt_s |=> !abort_req) // R10
        else $error("abort not released after engine stop");
    abort_hold_a: assert property (
        abort_req && !eng_stopped |=> abort_req) // R10
        else $error("abort dropped before engine stopped");
    pend_clear_a: assert property (
        ctl_wr && !reg_wdata[ctl_pend_bit] && !eng_done |=> !pend_r) // R9
        else $error("pending interrupt not cleared by zero write");
    pend_set_a: assert property (eng_done |=> pend_r) // R7
        else $error("completion not latched as pending");
    mode_bits_a: assert property (
        ctl_wr |=> master_mode == $past(reg_wdata[ctl_master_bit])
        && turbo_path == $past(reg_wdata[ctl_turbo_bit])) // R8
        else $error("mode bits not written");

    // interrupt pin: completion when enabled, else legacy source
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_out_pin_n <= 1'b1;
        end
        else if (irq_en_r)
        begin
            irq_out_pin_n <= !pend_r; // R7
        end
        else
        begin
            irq_out_pin_n <= legacy_irq_n; // R7
        end
    end

    irq_route_a: assert property (
        irq_out_pin_n == ($past(irq_en_r) ? !$past(pend_r)
        : $past(legacy_irq_n))) // R7
        else $error("interrupt pin routed wrongly");

    // command queue guard; free count taken live so bursts cannot overrun
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmd_push <= 1'b0;
            ovf_r <= queue_reset[q_ovf_bit];
        end
        else
        begin
            cmd_push <= cmd_wr && queue_free != 4'h0; // R14
            if (cmd_wr && queue_free == 4'h0)
            begin
                ovf_r <= 1'b1; // R14
            end
            else if (queue_rd)
            begin
                ovf_r <= 1'b0; // R15
            end
        end
    end
    overflow_drop_a: assert property (
        cmd_wr && queue_free == 4'h0 |=> ovf_r && !cmd_push) // R14
        else $error("excess command not dropped and flagged");
    overflow_clear_a: assert property (
        queue_rd && !(cmd_wr && queue_free == 4'h0) |=> !ovf_r) // R15
        else $error("overflow not cleared by status read");

    // descriptor banks; only the selected bank is read or written
    map_desc_mem u_desc (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(reg_wr && is_desc), // R22
        .wr_bank(map_select), // R22
        .wr_lane(lane), // R16
        .wr_data(reg_wdata & lane_mask(lane)), // R17
        .rd_bank(map_select), // R22
        .rd_data(desc_rd)
    );

    // bank index and the selected descriptor seen by the engine
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            map_select <= desc_sel_e'(select_reset);
            sel_sysmem <= 1'b0;
            sel_big_endian <= 1'b0;
            sel_bpp <= 6'h00;
        end
        else
        begin
            map_select <= (reg_wr && reg_addr == off_select)
                ? desc_sel_e'(reg_wdata[1:0]) : map_select; // R12
            sel_sysmem <= desc_rd[lane_format*8 + fmt_sysmem_bit]; // R21
            sel_big_endian <= desc_rd[lane_format*8 + fmt_endian_bit]; // R19
            sel_bpp <= depth_bits(desc_rd[lane_format*8 +: 3]); // R18
        end
    end

    // local registers; reserved bits read as zero
    always_comb
    begin
        local_val = 8'h00;
        if (reg_addr == off_status)
        begin
            local_val = status_r; // R6
        end
        else if (reg_addr == off_control)
        begin
            local_val[ctl_irq_en_bit] = irq_en_r;
            local_val[ctl_master_bit] = master_mode;
            local_val[ctl_pend_bit] = pend_r; // R9
            local_val[ctl_abort_bit] = abort_req;
            local_val[ctl_turbo_bit] = turbo_path;
        end
        else if (reg_addr == off_select)
        begin
            local_val[1:0] = map_select;
        end
        else if (reg_addr == off_queue)
        begin
            local_val[3:0] = queue_free; // R13
            local_val[q_ovf_bit] = ovf_r;
        end
    end

    // two-stage read: descriptor memory answers from a register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_p1_r <= 1'b0;
            desc_p1_r <= 1'b0;
            lane_p1_r <= 4'h0;
            local_p1_r <= 8'h00;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            rd_p1_r <= reg_rd;
            desc_p1_r <= is_desc;
            lane_p1_r <= lane;
            local_p1_r <= local_val; // R20
            reg_rvalid <= rd_p1_r;
            reg_rdata <= !rd_p1_r ? 8'h00
                : desc_p1_r ? desc_rd[lane_p1_r*8 +: 8] : local_p1_r; // R20
        end
    end
    sequence read_req_s;
        reg_rd ##2 reg_rvalid;
    endsequence
    property read_answer_p;
        reg_rd |-> read_req_s;
    endproperty
    read_latency_a: assert property (read_answer_p) // R20
        else $error("read not answered two cycles later");
    busy_read_a: assert property (
        reg_rd && reg_addr == off_status && abort_req && !eng_stopped
        |=> abort_req) // R6
        else $error("status read disturbed the engine");

endmodule : drawing_coproc_control_regs
`default_nettype wire

// >>> bench/engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module engine_model #(
    parameter int run_len = 24,
    parameter logic [3:0] depth = 4'h4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bench requests
    input wire logic start,
    input wire logic drain,
    // abort from the register block, command write from the bench
    input wire logic abort_req,
    input wire logic cmd_wr,
    // engine state back
    output logic eng_busy,
    output logic eng_done,
    output logic eng_stopped,
    output logic [3:0] queue_free
);
    int cnt_r;

    // abort wins over the normal end; no done pulse on a killed run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eng_busy <= 1'b0;
            eng_done <= 1'b0;
            eng_stopped <= 1'b0;
            cnt_r <= 0;
        end
        else
        begin
            eng_done <= 1'b0;
            eng_stopped <= 1'b0;
            if (start)
            begin
                eng_busy <= 1'b1;
                cnt_r <= run_len;
            end
            else if (abort_req)
            begin
                eng_busy <= 1'b0;
                eng_stopped <= 1'b1;
            end
            else if (eng_busy)
            begin
                cnt_r <= cnt_r - 1;
                eng_busy <= (cnt_r != 1);
                eng_done <= (cnt_r == 1);
            end
        end
    end

    // free count moves on the same edge as the word it takes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            queue_free <= depth;
        else if (drain)
            queue_free <= depth;
        else if (cmd_wr && queue_free != 4'h0)
            queue_free <= queue_free - 4'h1;
    end
endmodule : engine_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import coproc_regs_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, reg_rvalid, eng_write_dir;
    logic eng_map_valid, eng_restart, eng_next_line, eng_busy, eng_done;
    logic eng_stopped, cmd_wr, cmd_push, master_mode, abort_req;
    logic turbo_path, sel_sysmem, sel_big_endian, legacy_irq_n;
    logic irq_out_pin_n, start, drain;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] queue_free;
    logic [5:0] sel_bpp;
    map_kind_e eng_map_need;
    desc_sel_e map_select;
    int bad_count, n_tests, cyc, pushes;
    logic [7:0] fmt [4] = '{8'h08, 8'h73, 8'h84, 8'h05};
    logic [5:0] bpp [4] = '{6'h01, 6'h08, 6'h10, 6'h20};

    drawing_coproc_control_regs u_drawing_coproc_control_regs (.clk(clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .eng_map_need(eng_map_need),
        .eng_write_dir(eng_write_dir), .eng_map_valid(eng_map_valid),
        .eng_restart(eng_restart), .eng_next_line(eng_next_line),
        .eng_busy(eng_busy), .eng_done(eng_done),
        .eng_stopped(eng_stopped), .queue_free(queue_free),
        .cmd_wr(cmd_wr), .cmd_push(cmd_push), .master_mode(master_mode),
        .abort_req(abort_req), .turbo_path(turbo_path),
        .map_select(map_select), .sel_sysmem(sel_sysmem),
        .sel_big_endian(sel_big_endian), .sel_bpp(sel_bpp),
        .legacy_irq_n(legacy_irq_n), .irq_out_pin_n(irq_out_pin_n));

    engine_model u_engine_model (.clk(clk), .reset_n(reset_n),
        .start(start), .drain(drain), .abort_req(abort_req),
        .cmd_wr(cmd_wr), .eng_busy(eng_busy), .eng_done(eng_done),
        .eng_stopped(eng_stopped), .queue_free(queue_free));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // hang guard, well above the several hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cmd_push === 1'b1)
            pushes++;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // answer lands one edge after the taking edge; x stays if it never does
    task automatic rc(input logic [7:0] a, exp);
        logic [7:0] d;
        d = 8'hxx;
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            #1;
            if (reg_rvalid === 1'b1)
                d = reg_rdata;
        end
        chk($sformatf("read %h", a), d, exp);
    endtask : rc

    task automatic run_eng();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
    endtask : run_eng

    task automatic t_status();
        logic [4:0] v;
        wr(off_status, 8'hff);
        for (int i = 0; i < 8; i++)
        begin
            v = 5'(i * 11 + 3);
            @(posedge clk);
            eng_map_need <= map_kind_e'(v[1:0]);
            eng_write_dir <= v[2];
            eng_map_valid <= v[3];
            eng_restart <= v[4];
            eng_next_line <= v[0];
            rc(off_status, {2'b00, v[0], v});
        end
        @(posedge clk);
        {eng_write_dir, eng_map_valid, eng_restart, eng_next_line} <= 4'h0;
        eng_map_need <= map_pattern;
        $display("test status done");
    endtask : t_status

    task automatic t_control();
        wr(off_control, 8'hce);
        tick(2);
        chk("master", master_mode, 1);
        chk("turbo", turbo_path, 1);
        rc(off_control, 8'h42);
        wr(off_control, 8'h00);
        $display("test control done");
    endtask : t_control

    task automatic t_irq();
        wr(off_control, 8'h01);
        run_eng();
        for (int k = 0; k < 60 && irq_out_pin_n !== 1'b0; k++)
            tick(1);
        chk("pin", irq_out_pin_n, 0);
        rc(off_control, 8'h11);
        wr(off_control, 8'h11);
        tick(3);
        chk("pin", irq_out_pin_n, 0);
        wr(off_control, 8'h01);
        tick(3);
        chk("pin", irq_out_pin_n, 1);
        wr(off_control, 8'h00);
        run_eng();
        tick(40);
        rc(off_control, 8'h10);
        chk("pin", irq_out_pin_n, 1);
        @(posedge clk);
        legacy_irq_n <= 1'b0;
        tick(3);
        chk("pin", irq_out_pin_n, 0);
        @(posedge clk);
        legacy_irq_n <= 1'b1;
        wr(off_control, 8'h00);
        $display("test irq done");
    endtask : t_irq

    task automatic t_abort();
        run_eng();
        tick(4);
        rc(off_status, 8'h80);
        chk("busy", eng_busy, 1);
        wr(off_control, 8'h20);
        #1;
        chk("abort", abort_req, 1);
        for (int k = 0; k < 10 && abort_req !== 1'b0; k++)
            tick(1);
        chk("abort", abort_req, 0);
        rc(off_control, 8'h00);
        rc(off_status, 8'h00);
        $display("test abort done");
    endtask : t_abort

    task automatic t_queue();
        int p0;
        p0 = pushes;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk);
            cmd_wr <= 1'b1;
        end
        @(posedge clk);
        cmd_wr <= 1'b0;
        tick(2);
        chk("pushes", pushes - p0, 4);
        rc(off_queue, 8'h80);
        rc(off_queue, 8'h00);
        @(posedge clk);
        drain <= 1'b1;
        @(posedge clk);
        drain <= 1'b0;
        tick(2);
        rc(off_queue, 8'h04);
        $display("test queue done");
    endtask : t_queue

    task automatic t_desc();
        logic [71:0] d;
        for (int i = 0; i < 4; i++)
        begin
            wr(off_select, 8'(i));
            d = {fmt[i], 16'h5fa0 + 16'(i), 16'hfa50 + 16'(i),
                 32'hc3a55a00 + 32'(i)};
            for (int j = 0; j < 9; j++)
                wr(off_base + 8'(j), d[8*j +: 8]);
        end
        for (int i = 3; i >= 0; i--)
        begin
            wr(off_select, 8'(i));
            tick(2);
            chk("select", map_select, i);
            chk("bpp", sel_bpp, bpp[i]);
            chk("endian", sel_big_endian, fmt[i][3]);
            chk("sysmem", sel_sysmem, fmt[i][7]);
            rc(off_select, 8'(i));
            d = {fmt[i] & 8'h8f, 4'h0, 12'hfa0 + 12'(i), 4'h0,
                 12'ha50 + 12'(i), 32'hc3a55a00 + 32'(i)};
            for (int j = 0; j < 9; j++)
                rc(off_base + 8'(j), d[8*j +: 8]);
        end
        rc(8'h30, 8'h00);
        $display("test descriptors done");
    endtask : t_desc

    initial
    begin
        {reset_n, reg_wr, reg_rd, cmd_wr, start, drain} = 6'h00;
        {eng_write_dir, eng_map_valid, eng_restart, eng_next_line} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        eng_map_need = map_pattern;
        legacy_irq_n = 1'b1;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        tick(1);
        chk("pin", irq_out_pin_n, 1);
        rc(off_control, 8'h00);
        rc(off_queue, 8'h04);
        $display("test reset done");
        t_status();
        t_control();
        t_irq();
        t_abort();
        t_queue();
        t_desc();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
